// ==== core/lvgm_cmp.sv ====
// One threshold comparator with hysteresis for a single monitored quantity.
// Assumes value and threshold are unsigned in the same engineering scale.
`timescale 1ns/1ps
module lvgm_cmp
  import lvgm_pkg::*;
#(
  parameter int W = LVGM_VAL_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] value_i,
  input  wire logic [W-1:0] thr_i,
  input  wire logic [W-1:0] nominal_i,
  input  wire logic [6:0]   hyst_i,
  input  wire logic         gt_i,
  output logic              breach_o
);
  typedef struct packed {
    logic breach;
  } lvgm_cmp_s;

  lvgm_cmp_s    st;
  lvgm_cmp_s    next_st;
  logic [6:0]   hyst_lim;
  logic [W+6:0] prod;
  logic [W-1:0] band;
  logic [W:0]   thr_up;
  logic [W:0]   thr_dn;

  // Hysteresis band is hyst/1000 of nominal, clamped to its legal span.
  always_comb begin
    hyst_lim = hyst_i;
    if (hyst_i < LVGM_HYST_MIN) begin
      hyst_lim = LVGM_HYST_MIN;
    end else if (hyst_i > LVGM_HYST_MAX) begin
      hyst_lim = LVGM_HYST_MAX;
    end
    prod   = nominal_i * hyst_lim;
    band   = W'(prod / (W + 7)'(1000));
    thr_up = {1'b0, thr_i} + {1'b0, band};
    thr_dn = {1'b0, thr_i} - {1'b0, band};
  end

  always_comb begin
    next_st = st;
    if (gt_i) begin
      if (!st.breach) begin
        next_st.breach = value_i > thr_i;
      end else begin
        next_st.breach = {1'b0, value_i} > thr_dn || thr_dn[W];
      end
    end else begin
      if (!st.breach) begin
        next_st.breach = value_i < thr_i;
      end else begin
        next_st.breach = {1'b0, value_i} < thr_up;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign breach_o = st.breach;

  a_cmp_gt_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (gt_i && $stable(gt_i) && !breach_o && value_i > thr_i) |=> breach_o)
    else $error("comparator missed an over-threshold value");
endmodule : lvgm_cmp

// ==== core/lvgm_pkg.sv ====
// Package for the limit value group monitor: register map, field layout and timing.
// Assumes a 125 MHz system clock and 32-bit APB.
package lvgm_pkg;

  localparam int          LVGM_GROUPS      = 7;
  localparam int          LVGM_QTY         = 6;
  localparam int          LVGM_COUNTERS    = 4;
  localparam int          LVGM_VAL_W       = 16;
  localparam int          LVGM_SEL_W       = 5;

  // Quantity source classes, decoded from the top two bits of a select code.
  localparam logic [1:0]  LVGM_CLS_VOLT    = 2'h0;
  localparam logic [1:0]  LVGM_CLS_CURR    = 2'h1;
  localparam logic [1:0]  LVGM_CLS_POWER   = 2'h2;
  localparam logic [1:0]  LVGM_CLS_ANALOG  = 2'h3;

  // Timing: filter steps of 0.1 s.
  localparam int          LVGM_CLK_HZ      = 125000000;
  localparam int          LVGM_STEP_MS     = 100;
  localparam int          LVGM_STEP_CYC    = LVGM_CLK_HZ / 1000 * LVGM_STEP_MS;
  localparam logic [6:0]  LVGM_FILT_MAX    = 7'h63;
  // Hysteresis in 0.1 % units of nominal: 1 to 100.
  localparam logic [6:0]  LVGM_HYST_MIN    = 7'h01;
  localparam logic [6:0]  LVGM_HYST_MAX    = 7'h64;

  // Register map. Group g config at GRP_BASE + g*0x40, quantity q at + q*0x08.
  localparam logic [11:0] LVGM_STAT_OFS    = 12'h000;
  localparam logic [11:0] LVGM_CLR_OFS     = 12'h004;
  localparam logic [11:0] LVGM_IEN_OFS     = 12'h008;
  localparam logic [11:0] LVGM_ALARM_OFS   = 12'h00c;
  localparam logic [11:0] LVGM_ROUTE_OFS   = 12'h010;
  localparam logic [11:0] LVGM_CAPT_OFS    = 12'h014;
  localparam logic [11:0] LVGM_TRIG_OFS    = 12'h018;
  localparam logic [11:0] LVGM_CNT_OFS     = 12'h020;
  localparam logic [11:0] LVGM_GRP_BASE    = 12'h100;
  localparam logic [11:0] LVGM_GRP_STRIDE  = 12'h040;
  localparam logic [11:0] LVGM_QTY_STRIDE  = 12'h008;

  // Group control word fields.
  localparam int          LVGM_GC_FILT_LSB = 0;
  localparam int          LVGM_GC_OR_BIT   = 8;
  localparam int          LVGM_GC_EN_LSB   = 16;
  // Quantity word 0 fields: threshold, select, direction, hysteresis.
  localparam int          LVGM_QC_THR_LSB  = 0;
  localparam int          LVGM_QC_SEL_LSB  = 16;
  localparam int          LVGM_QC_GT_BIT   = 23;
  localparam int          LVGM_QC_HYS_LSB  = 24;

  localparam logic [31:0] LVGM_RST_WORD    = 32'h0000_0000;
  localparam logic [6:0]  LVGM_RST_HYST    = 7'h01;

endpackage : lvgm_pkg

// ==== core/lvgm_top.sv ====
// Limit value group monitor: seven groups of up to six compared quantities, AND/OR
// combine, filter time, alarm routing to outputs, counters and recorder trigger.
// Assumes measured values arrive on the system clock from measurement processing.
// Notes on behaviour
// - Seven independent groups; group seven accepts voltage quantities only.
// - Each quantity tests greater or less than its threshold, selectable.
// - Up to six results combine by AND or OR; power quantities excluded.
// - Alarm raised after breach persists for filter time, 0 to 9.9 s steps.
// - Hysteresis 0.1 to 10 percent of the quantity nominal value.
// - Each group alarm routes to a binary output or an internal counter.
// - Only groups one to six may trigger the waveform recorder.
// - Group seven monitors voltages live and captures the violating value.
// - Four internal counters, each assignable to one limit group.
// - Analog input channels are selectable as monitored quantities.
`timescale 1ns/1ps
module lvgm_top
  import lvgm_pkg::*;
#(
  parameter int NSRC     = 32,
  parameter int STEP_CYC = LVGM_STEP_CYC
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         psel_i,
  input  wire logic                         penable_i,
  input  wire logic                         pwrite_i,
  input  wire logic [11:0]                  paddr_i,
  input  wire logic [31:0]                  pwdata_i,
  output logic      [31:0]                  prdata_o,
  output logic                              pready_o,
  output logic                              pslverr_o,
  input  wire logic [NSRC*LVGM_VAL_W-1:0]   meas_i,
  input  wire logic [NSRC*LVGM_VAL_W-1:0]   nominal_i,
  output logic      [LVGM_GROUPS-1:0]       alarm_o,
  output logic      [LVGM_GROUPS-1:0]       binout_o,
  output logic                              scope_trig_o,
  output logic                              irq_o
);
  localparam int G = LVGM_GROUPS;
  localparam int Q = LVGM_QTY;
  localparam int V = LVGM_VAL_W;

  typedef struct packed {
    logic [G-1:0][31:0]          gctl;
    logic [G-1:0][Q-1:0][31:0]   qcfg;
    logic [G-1:0][6:0]           fcnt;
    logic [G-1:0]                alarm;
    logic [31:0]                 tick;
    logic                        step;
    logic [G-1:0]                route_cnt;
    logic [G-1:0]                trig_en;
    logic [LVGM_COUNTERS-1:0][3:0]  cnt_grp;
    logic [LVGM_COUNTERS-1:0][31:0] cnt;
    logic [V-1:0]                capt;
    logic [G-1:0]                stat;
    logic [G-1:0]                ien;
    logic [31:0]                 rdata;
    logic                        trig;
  } lvgm_top_s;

  lvgm_top_s st;
  lvgm_top_s next_st;

  logic [G-1:0][Q-1:0] breach;
  logic [G-1:0][Q-1:0] q_on;
  logic [G-1:0]        comb;
  logic [G-1:0]        rise;

  // A select is legal if it is not power, and for the voltage-only group, voltage.
  function automatic logic sel_ok(input logic [LVGM_SEL_W-1:0] sel, input int g);
    logic [1:0] cls;
    cls = sel[LVGM_SEL_W-1 -: 2];
    sel_ok = (cls != LVGM_CLS_POWER) && (g != G - 1 || cls == LVGM_CLS_VOLT);
  endfunction : sel_ok

  function automatic logic [V-1:0] pick(input logic [NSRC*V-1:0] bus,
                                        input logic [LVGM_SEL_W-1:0] sel);
    pick = bus[int'(sel)*V +: V];
  endfunction : pick

  genvar gi, qi;
  generate
    for (gi = 0; gi < G; gi++) begin : g_grp
      for (qi = 0; qi < Q; qi++) begin : g_qty
        logic [LVGM_SEL_W-1:0] sel;
        assign sel = st.qcfg[gi][qi][LVGM_QC_SEL_LSB +: LVGM_SEL_W];
        // Enables sit apart from the combine select, so AND may use all six quantities.
        assign q_on[gi][qi] = st.gctl[gi][LVGM_GC_EN_LSB + qi] && sel_ok(sel, gi);
        lvgm_cmp #(.W(V)) u_cmp (
          .clk_i     (clk_i),
          .rst_i     (rst_i),
          .value_i   (pick(meas_i, sel)),
          .thr_i     (st.qcfg[gi][qi][LVGM_QC_THR_LSB +: V]),
          .nominal_i (pick(nominal_i, sel)),
          .hyst_i    (st.qcfg[gi][qi][LVGM_QC_HYS_LSB +: 7]),
          .gt_i      (st.qcfg[gi][qi][LVGM_QC_GT_BIT]),
          .breach_o  (breach[gi][qi])
        );
      end
      // Disabled quantities are neutral: true for AND, false for OR.
      always_comb begin
        if (st.gctl[gi][LVGM_GC_OR_BIT]) begin
          comb[gi] = |(breach[gi] & q_on[gi]);
        end else begin
          comb[gi] = (q_on[gi] != '0) && &(breach[gi] | ~q_on[gi]);
        end
      end
    end
  endgenerate

  logic        acc;
  logic        wr;
  logic [11:0] gofs;
  logic [2:0]  gidx;
  logic [2:0]  qidx;
  logic        in_grp;
  logic        hit;

  assign acc    = psel_i && penable_i;
  assign wr     = acc && pwrite_i;
  assign gofs   = paddr_i - LVGM_GRP_BASE;
  assign gidx   = gofs[8:6];
  assign qidx   = gofs[5:3];
  // Offsets past the last group must not fold back onto a group through gofs.
  assign in_grp = paddr_i >= LVGM_GRP_BASE && gofs[11:9] == 3'h0 && gidx < 3'(G) &&
                  paddr_i[1:0] == 2'h0;

  always_comb begin
    next_st = st;
    rise    = '0;
    hit     = 1'b1;
    // Filter tick every 0.1 s.
    next_st.step = 1'b0;
    if (st.tick >= 32'(STEP_CYC - 1)) begin
      next_st.tick = '0;
      next_st.step = 1'b1;
    end else begin
      next_st.tick = st.tick + 32'h1;
    end
    for (int g = 0; g < G; g++) begin
      // The count restarts on any break in the breach, so only a continuous
      // breach reaches the filter value; setting zero alarms in one cycle.
      if (!comb[g]) begin
        next_st.fcnt[g]  = '0;
        next_st.alarm[g] = 1'b0;
      end else if (st.fcnt[g] >= st.gctl[g][LVGM_GC_FILT_LSB +: 7] ||
                   st.fcnt[g] >= LVGM_FILT_MAX) begin
        next_st.alarm[g] = 1'b1;
      end else if (st.step) begin
        next_st.fcnt[g] = st.fcnt[g] + 7'h1;
      end
      rise[g] = next_st.alarm[g] && !st.alarm[g];
    end
    // Group seven captures the first violating voltage of each alarm.
    if (rise[G-1]) begin
      for (int q = Q - 1; q >= 0; q--) begin
        if (breach[G-1][q] && q_on[G-1][q]) begin
          next_st.capt = pick(meas_i, st.qcfg[G-1][q][LVGM_QC_SEL_LSB +: LVGM_SEL_W]);
        end
      end
    end
    for (int c = 0; c < LVGM_COUNTERS; c++) begin
      if (st.cnt_grp[c] < 4'(G) && st.route_cnt[st.cnt_grp[c][2:0]] &&
          rise[st.cnt_grp[c][2:0]]) begin
        next_st.cnt[c] = st.cnt[c] + 32'h1;
      end
    end
    next_st.trig = |(rise[G-2:0] & st.trig_en[G-2:0]);
    // Sticky status; a new alarm wins over a clear in the same cycle.
    next_st.stat = st.stat;
    if (wr && paddr_i == LVGM_CLR_OFS) begin
      next_st.stat = st.stat & ~pwdata_i[G-1:0];
    end
    next_st.stat = next_st.stat | rise;
    next_st.rdata = '0;
    if (wr) begin
      if (in_grp && gofs[2]) begin
        hit = 1'b0;
      end else if (in_grp && qidx < 3'(Q)) begin
        next_st.qcfg[gidx][qidx] = pwdata_i;
      end else if (in_grp && qidx == 3'h7) begin
        next_st.gctl[gidx] = pwdata_i;
      end else begin
        case (paddr_i)
          LVGM_CLR_OFS:   hit = 1'b1;
          LVGM_IEN_OFS:   next_st.ien = pwdata_i[G-1:0];
          LVGM_ROUTE_OFS: next_st.route_cnt = pwdata_i[G-1:0];
          LVGM_TRIG_OFS:  next_st.trig_en = {1'b0, pwdata_i[G-2:0]};
          LVGM_CNT_OFS:   begin
            for (int c = 0; c < LVGM_COUNTERS; c++) begin
              next_st.cnt_grp[c] = pwdata_i[c*8 +: 4];
            end
          end
          default:        hit = 1'b0;
        endcase
      end
    end else if (acc) begin
      if (in_grp && gofs[2]) begin
        hit = 1'b0;
      end else if (in_grp && qidx < 3'(Q)) begin
        next_st.rdata = st.qcfg[gidx][qidx];
      end else if (in_grp && qidx == 3'h7) begin
        next_st.rdata = st.gctl[gidx];
      end else if (paddr_i >= LVGM_CNT_OFS + 12'h4 &&
                   paddr_i < LVGM_CNT_OFS + 12'h4 + 12'(4 * LVGM_COUNTERS) &&
                   paddr_i[1:0] == 2'h0) begin
        next_st.rdata = st.cnt[paddr_i[3:2] - 2'h1];
      end else begin
        case (paddr_i)
          LVGM_STAT_OFS:  next_st.rdata = 32'(st.stat);
          LVGM_CLR_OFS:   next_st.rdata = '0;
          LVGM_IEN_OFS:   next_st.rdata = 32'(st.ien);
          LVGM_ALARM_OFS: next_st.rdata = 32'(st.alarm);
          LVGM_ROUTE_OFS: next_st.rdata = 32'(st.route_cnt);
          LVGM_CAPT_OFS:  next_st.rdata = 32'(st.capt);
          LVGM_TRIG_OFS:  next_st.rdata = 32'(st.trig_en);
          LVGM_CNT_OFS:   begin
            for (int c = 0; c < LVGM_COUNTERS; c++) begin
              next_st.rdata[c*8 +: 4] = st.cnt_grp[c];
            end
          end
          default:        hit = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      for (int g = 0; g < G; g++) begin
        for (int q = 0; q < Q; q++) begin
          st.qcfg[g][q][LVGM_QC_HYS_LSB +: 7] <= LVGM_RST_HYST;
        end
      end
      for (int c = 0; c < LVGM_COUNTERS; c++) begin
        st.cnt_grp[c] <= 4'hf;
      end
    end else begin
      st <= next_st;
    end
  end

  // Read data is registered, so the access phase takes exactly two cycles.
  logic rd_wait;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_wait <= 1'b0;
    end else begin
      rd_wait <= acc && !rd_wait;
    end
  end

  logic err_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_q <= 1'b0;
    end else begin
      err_q <= acc && !rd_wait && !hit;
    end
  end

  assign pready_o     = rd_wait;
  assign pslverr_o    = rd_wait && err_q;
  assign prdata_o     = st.rdata;
  assign alarm_o      = st.alarm;
  assign binout_o     = st.alarm & ~st.route_cnt;
  assign scope_trig_o = st.trig;
  assign irq_o        = |(st.stat & st.ien);

  a_filter_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(alarm_o[0]) |-> $past(comb[0]))
    else $error("alarm rose without a breach");
  a_alarm_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    !comb[1] |=> !alarm_o[1])
    else $error("alarm held after breach ended");
  // Group seven may alarm freely but must never reach the recorder trigger.
  a_no_trig_g7: assert property (@(posedge clk_i) disable iff (rst_i)
    (rise[G-1] && rise[G-2:0] == '0) |=> !scope_trig_o)
    else $error("group seven alone raised the recorder trigger");
  a_trig_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    scope_trig_o |-> $past(|rise[G-2:0]))
    else $error("recorder trigger without a group alarm");
  a_g7_volt: assert property (@(posedge clk_i) disable iff (rst_i)
    q_on[G-1][0] |-> st.qcfg[G-1][0][LVGM_QC_SEL_LSB+3 +: 2] == LVGM_CLS_VOLT)
    else $error("group seven enabled a non-voltage quantity");
  a_no_power: assert property (@(posedge clk_i) disable iff (rst_i)
    q_on[0][0] |-> st.qcfg[0][0][LVGM_QC_SEL_LSB+3 +: 2] != LVGM_CLS_POWER)
    else $error("power quantity enabled");
  a_bin_route: assert property (@(posedge clk_i) disable iff (rst_i)
    binout_o[2] |-> alarm_o[2] && !st.route_cnt[2])
    else $error("binary output without routed alarm");
  a_cnt_step: assert property (@(posedge clk_i) disable iff (rst_i)
    st.cnt[0] != $past(st.cnt[0]) |-> st.cnt[0] == $past(st.cnt[0]) + 32'h1)
    else $error("counter moved by more than one");
  a_capt_on_rise: assert property (@(posedge clk_i) disable iff (rst_i)
    st.capt != $past(st.capt) |-> $past(rise[G-1]))
    else $error("capture changed without group seven alarm");
endmodule : lvgm_top

// ==== tb/lvgm_meas_model.sv ====
// Model of the measurement processing side: live and nominal values per source.
// Assumes the bench changes values through set_meas only.
`timescale 1ns/1ps
module lvgm_meas_model
  import lvgm_pkg::*;
#(
  parameter int NSRC = 32
) (
  input  wire logic                       clk_i,
  output logic      [NSRC*LVGM_VAL_W-1:0] meas_o,
  output logic      [NSRC*LVGM_VAL_W-1:0] nominal_o
);
  logic [LVGM_VAL_W-1:0] val [NSRC];

  // Sources 24 and up stand for the optional analog inputs, same scale as the rest.
  always_comb begin
    for (int s = 0; s < NSRC; s++) begin
      meas_o[s*LVGM_VAL_W+:LVGM_VAL_W]    = val[s];
      nominal_o[s*LVGM_VAL_W+:LVGM_VAL_W] = 16'h03e8;
    end
  end

  initial begin
    for (int s = 0; s < NSRC; s++) begin
      val[s] = '0;
    end
  end

  // Values move only just after a clock edge, as the live measurement path does.
  task automatic set_meas(input int s, input logic [LVGM_VAL_W-1:0] v);
    @(posedge clk_i);
    val[s] <= v;
  endtask : set_meas
endmodule : lvgm_meas_model

// ==== tb/lvgm_tb_top.sv ====
// Self-checking bench for the limit value group monitor over APB.
// Assumes a filter step shortened to 10 clock cycles.
`timescale 1ns/1ps
`define LVGM_CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
  err_count++; $display("MISMATCH %s exp %h seen %h", nm, ex, got); end end
module lvgm_tb_top;
  import lvgm_pkg::*;
  localparam int NSRC = 32;
  localparam int STEP = 10;
  typedef struct packed {logic rd; logic err; logic [31:0] data;} lvgm_note_s;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, scope_trig, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [LVGM_GROUPS-1:0] alarm, binout;
  logic [NSRC*LVGM_VAL_W-1:0] meas, nominal;
  lvgm_note_s notes[$];
  lvgm_note_s note;
  int err_count, total_checks, cyc, trig_cnt;
  logic [15:0] v;

  lvgm_meas_model #(.NSRC(NSRC)) i_lvgm_meas_model (.clk_i(clk), .meas_o(meas),
    .nominal_o(nominal));
  lvgm_top #(.NSRC(NSRC), .STEP_CYC(STEP)) i_lvgm_top (.clk_i(clk), .rst_i(rst),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .meas_i(meas), .nominal_i(nominal), .alarm_o(alarm), .binout_o(binout),
    .scope_trig_o(scope_trig), .irq_o(irq));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // Answers are judged where pready is sampled, against the oldest note.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (scope_trig === 1'b1) trig_cnt <= trig_cnt + 1;
    if (psel && penable && pready === 1'b1) begin
      note = notes.pop_front();
      `LVGM_CHK("pslverr", note.err, pslverr)
      if (note.rd) `LVGM_CHK("prdata", note.data, prdata)
    end
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic err, input logic [31:0] ex);
    notes.push_back({!wr, err, ex});
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, '0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ex);
    apb(1'b0, a, '0, 1'b0, ex);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // Bounded wait; the caller judges the level reached.
  task automatic wait_al(input int g, input logic lvl, input int n);
    @(negedge clk);
    repeat (n) if (alarm[g] !== lvl) @(negedge clk);
  endtask : wait_al

  function automatic logic [11:0] ga(input int g, input int ofs);
    return LVGM_GRP_BASE + 12'(g) * LVGM_GRP_STRIDE + 12'(ofs);
  endfunction : ga

  function automatic logic [31:0] qw(input logic [6:0] h, input logic gt,
                                     input logic [4:0] s, input logic [15:0] t);
    return {1'b0, h, gt, 2'b00, s, t};
  endfunction : qw

  initial begin
    {psel, penable, pwrite, rst} = 4'b0001;
    paddr = '0;
    pwdata = '0;
    err_count = 0;
    total_checks = 0;
    cyc = 0;
    trig_cnt = 0;
    v = 16'($urandom(32'h50bb));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(LVGM_STAT_OFS, '0);
    rd(LVGM_ALARM_OFS, '0);
    rd(LVGM_IEN_OFS, '0);
    rd(LVGM_CLR_OFS, '0);
    rd(ga(0, 0), 32'h0100_0000);
    rd(LVGM_CNT_OFS, 32'h0f0f_0f0f);
    apb(1'b0, 12'h0fc, '0, 1'b1, '0);
    wr(LVGM_TRIG_OFS, 32'h0000_007f);
    rd(LVGM_TRIG_OFS, 32'h0000_003f);
    for (int s = 9; s < 24; s++) i_lvgm_meas_model.set_meas(s, 16'($urandom));
    // Group 1 of 7: above 1000 with a 10 % band and a one second filter.
    v = 16'h03e9 + 16'($urandom_range(499));
    wr(ga(0, 0), qw(7'h64, 1'b1, 5'h00, 16'h03e8));
    wr(ga(0, 'h38), 32'h0001_000a);
    i_lvgm_meas_model.set_meas(0, v);
    idle(9 * STEP - 4);
    `LVGM_CHK("early alarm", 1'b0, alarm[0])
    wait_al(0, 1'b1, 40);
    `LVGM_CHK("alarm high side", 1'b1, alarm[0])
    `LVGM_CHK("binout", 1'b1, binout[0])
    rd(LVGM_STAT_OFS, 32'h0000_0001);
    `LVGM_CHK("irq masked", 1'b0, irq)
    wr(LVGM_IEN_OFS, 32'h0000_0001);
    idle(2);
    `LVGM_CHK("irq", 1'b1, irq)
    wr(LVGM_CLR_OFS, 32'h0000_0001);
    idle(2);
    `LVGM_CHK("irq cleared", 1'b0, irq)
    rd(LVGM_STAT_OFS, '0);
    `LVGM_CHK("scope trig", 1, trig_cnt)
    i_lvgm_meas_model.set_meas(0, 16'h03b6);
    idle(3 * STEP);
    `LVGM_CHK("hyst hold", 1'b1, alarm[0])
    i_lvgm_meas_model.set_meas(0, 16'h0352);
    wait_al(0, 1'b0, 40);
    `LVGM_CHK("hyst release", 1'b0, alarm[0])
    wr(ga(0, 'h38), '0);
    i_lvgm_meas_model.set_meas(0, 16'h0000);
    // Group 2: analog source below 500, zero filter, routed to counter 0.
    i_lvgm_meas_model.set_meas(24, 16'h0258);
    wr(ga(1, 0), qw(7'h01, 1'b0, 5'h18, 16'h01f4));
    wr(LVGM_ROUTE_OFS, 32'h0000_0002);
    wr(LVGM_CNT_OFS, 32'h0f0f_0f01);
    wr(ga(1, 'h38), 32'h0001_0000);
    for (int k = 1; k <= 2; k++) begin
      i_lvgm_meas_model.set_meas(24, 16'h0190);
      wait_al(1, 1'b1, 20);
      `LVGM_CHK("alarm low side", 1'b1, alarm[1])
      `LVGM_CHK("binout routed", 1'b0, binout[1])
      rd(LVGM_CNT_OFS + 12'h004, k);
      i_lvgm_meas_model.set_meas(24, 16'h0258);
      wait_al(1, 1'b0, 20);
    end
    wr(ga(1, 'h38), '0);
    // Group 3: two quantities combined by AND, then by OR.
    wr(ga(2, 8), qw(7'h01, 1'b1, 5'h01, 16'h0064));
    wr(ga(2, 16), qw(7'h01, 1'b1, 5'h02, 16'h0064));
    wr(ga(2, 'h38), 32'h0006_0000);
    i_lvgm_meas_model.set_meas(1, 16'h00c8);
    idle(10);
    `LVGM_CHK("and one", 1'b0, alarm[2])
    i_lvgm_meas_model.set_meas(2, 16'h00c8);
    wait_al(2, 1'b1, 20);
    `LVGM_CHK("and both", 1'b1, alarm[2])
    i_lvgm_meas_model.set_meas(1, 16'h0000);
    wait_al(2, 1'b0, 20);
    `LVGM_CHK("and dropped", 1'b0, alarm[2])
    wr(ga(2, 'h38), 32'h0006_0100);
    wait_al(2, 1'b1, 20);
    `LVGM_CHK("or one", 1'b1, alarm[2])
    wr(ga(2, 'h38), '0);
    i_lvgm_meas_model.set_meas(2, 16'h0000);
    // Group 4: a power source is refused even though its value breaches.
    i_lvgm_meas_model.set_meas(16, 16'h0064);
    wr(ga(3, 0), qw(7'h01, 1'b1, 5'h10, 16'h0032));
    wr(ga(3, 'h38), 32'h0001_0000);
    idle(20);
    `LVGM_CHK("power in group 4", 1'b0, alarm[3])
    wr(ga(3, 'h38), '0);
    // Group 7: a current source is refused, a voltage breach is captured.
    i_lvgm_meas_model.set_meas(8, 16'h012c);
    wr(ga(6, 0), qw(7'h01, 1'b1, 5'h08, 16'h00c8));
    wr(ga(6, 'h38), 32'h0001_0000);
    idle(20);
    `LVGM_CHK("current in group 7", 1'b0, alarm[6])
    wr(ga(6, 0), qw(7'h01, 1'b1, 5'h02, 16'h00c8));
    i_lvgm_meas_model.set_meas(2, 16'h012c);
    wait_al(6, 1'b1, 20);
    `LVGM_CHK("group 7 alarm", 1'b1, alarm[6])
    rd(LVGM_CAPT_OFS, 32'h0000_012c);
    `LVGM_CHK("scope trig", 5, trig_cnt)
    stop_test();
  end
endmodule : lvgm_tb_top
